// >>> shared/brownout_cfg.svh
// offsets, field positions, reset values for the brown-out / low-voltage block
// assumes a 32-bit register port with byte addresses on 8 bits
`ifndef BROWNOUT_CFG_SVH
`define BROWNOUT_CFG_SVH
// register byte offsets
`define OFS_BOD_CTRL 8'h0c
`define OFS_GLITCH_SEL 8'h10
`define OFS_AON_SYNC 8'h40
`define OFS_IRQ_STATUS 8'h44
`define OFS_IRQ_CLEAR 8'h48
`define OFS_IRQ_ENABLE 8'h4c
// control/status field positions
`define POS_BOD_TEST 22
`define POS_LVR_TEST 21
`define POS_THR_HI 20
`define POS_THR_LO 18
`define POS_BROWNOUT_DETECTOR_ENABLE_ALIAS 17
`define POS_LVR_EN 16
`define POS_BOD_OUT 6
`define POS_BOD_FLAG 4
`define POS_RESP_SEL 3
// glitch selector field positions
`define POS_LVR_DB_HI 13
`define POS_LVR_DB_LO 8
`define POS_BOD_DB_HI 5
`define POS_BOD_DB_LO 0
// reset values
`define RST_BOD_CTRL 32'h000c_0040
`define RST_GLITCH_SEL 32'h0000_0101
// threshold code meaning no threshold
`define THR_NONE 3'h7
// event bit positions in status, clear and enable
`define EV_CROSS 0
`define EV_BOD_RESET 1
`define EV_LVR_TRIP 2
`endif

// >>> shared/brownout_pkg.sv
// types shared by the brown-out / low-voltage control block
// assumes nothing beyond a SystemVerilog compiler
package brownout_pkg;
  // one register access from software
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // always-on fields as written by software, and their synced copy
  typedef struct packed {
    logic brownout_test_enable;
    logic lowvolt_reset_test_enable;
    logic [2:0] brownout_threshold_select;
    logic brownout_detector_enable;
    logic lowvolt_reset_enable;
    logic brownout_response_select;
    logic [5:0] lowvolt_glitch_time_select;
    logic [5:0] brownout_glitch_time_select;
  } aon_fields_t;

  // controls driven to the analog comparators
  typedef struct packed {
    logic brownout_test_enable;
    logic lowvolt_reset_test_enable;
    logic [2:0] brownout_threshold_select;
    logic brownout_detector_enable;
    logic lowvolt_reset_enable;
  } analog_ctrl_t;
endpackage

// >>> rtl/supply_glitch_filter.sv
// glitch filter for one comparator output, counted in slow-clock ticks
// assumes comparator input and tick are already synchronous to ref_clk
`timescale 1ns/1ps
module supply_glitch_filter (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic slow_tick,
  input wire logic [5:0] time_select,
  input wire logic raw_in,
  output logic filtered_out
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic out_reg;
  logic out_next;
  logic [5:0] target;

  // lowest set bit wins; an all-zero selector falls back to one tick
  // lowest bit priority
  always_comb
  begin
    target = 6'h01;
    for (int k = 5; k >= 0; k--)
    begin
      if (time_select[k])
      begin
        target = 6'(1 << k);
      end
    end
  end

  // new level must hold for the full count before it passes
  // hold before update
  always_comb
  begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (raw_in == out_reg)
    begin
      cnt_next = 6'h00; // any bounce restarts the wait
    end
    else if (slow_tick)
    begin
      if (cnt_reg + 6'h01 >= target)
      begin
        out_next = raw_in;
        cnt_next = 6'h00;
      end
      else
      begin
        cnt_next = cnt_reg + 6'h01;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_reg <= 6'h00;
      out_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign filtered_out = out_reg;
endmodule // supply_glitch_filter

// >>> rtl/brownout_lvr_control.sv
// control and status for the brown-out detector and low-voltage reset
// assumes a one-cycle register port, a synchronous slow clock level,
// comparator outputs that are high while the supply is below the trip level
// and a lock input from the chip's register protection controller
//
// Overview of operation
// - three-bit threshold code 000..110 picks 1.75-2.95 V; 111 means none
// - detector enable bit; cleared disables flag and response, status still shows the inverted filtered comparator
// - low-voltage reset enable bit turns on the 1.7 V comparator
// - read-only status is 1 above threshold, inverted comparator output
// - crossing either way sets flag; interrupt raised on a crossing to below when interrupt response chosen
// - enabled and below threshold: interrupt if select 0, chip reset if 1
// - response select is writable only while register protection is unlocked
// - brown-out interrupt stays until detector enable is cleared
// - low-voltage glitch time one-hot, bit k means 2^k slow clocks
// - brown-out glitch time one-hot, bit k means 2^k slow clocks
// - several selector bits set: lowest numbered one is used
// - separate analog test enables for both comparators, 1 means test
`timescale 1ns/1ps
module brownout_lvr_control (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire brownout_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic regs_unlocked,
  input wire logic slow_clk,
  input wire logic brownout_cmp_raw,
  input wire logic lowvolt_cmp_raw,
  output brownout_pkg::analog_ctrl_t analog_ctrl,
  output logic brownout_irq,
  output logic chip_reset_req,
  output logic lowvolt_reset_req,
  output logic irq
);
  import brownout_pkg::*;
  `include "brownout_cfg.svh"

  aon_fields_t cfg_reg;
  aon_fields_t cfg_next;
  aon_fields_t aon_reg;
  aon_fields_t aon_next;
  logic sync_en_reg;
  logic sync_en_next;
  logic flag_reg;
  logic flag_next;
  logic bod_irq_reg;
  logic bod_irq_next;
  logic chip_rst_reg;
  logic chip_rst_next;
  logic lvr_rst_reg;
  logic lvr_rst_next;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] irq_en_reg;
  logic [2:0] irq_en_next;
  logic irq_reg;
  logic irq_next;
  logic below_q_reg;
  logic slow_q_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic slow_tick;
  logic bod_below_f;
  logic lvr_below_f;
  logic bod_active;
  logic crossing;
  logic [2:0] events;
  logic wr_ctrl;
  logic wr_glitch;
  logic [31:0] ctrl_view;
  logic [31:0] glitch_view;

  // reset words held as constants so their fields can be sliced
  localparam logic [31:0] ctrl_rst_word = `RST_BOD_CTRL;
  localparam logic [31:0] glitch_rst_word = `RST_GLITCH_SEL;
  // reset image of the fields; a constant keeps the async reset branch clean
  localparam aon_fields_t cfg_rst = '{
    brownout_test_enable: ctrl_rst_word[`POS_BOD_TEST],
    lowvolt_reset_test_enable: ctrl_rst_word[`POS_LVR_TEST],
    brownout_threshold_select: ctrl_rst_word[`POS_THR_HI:`POS_THR_LO],
    brownout_detector_enable: ctrl_rst_word[`POS_BROWNOUT_DETECTOR_ENABLE_ALIAS],
    lowvolt_reset_enable: ctrl_rst_word[`POS_LVR_EN],
    brownout_response_select: ctrl_rst_word[`POS_RESP_SEL],
    lowvolt_glitch_time_select: glitch_rst_word[`POS_LVR_DB_HI:`POS_LVR_DB_LO],
    brownout_glitch_time_select: glitch_rst_word[`POS_BOD_DB_HI:`POS_BOD_DB_LO]
  };

  // slow clock is a synchronous level here; its rising edge is a tick
  assign slow_tick = slow_clk & ~slow_q_reg;

  // glitch filters run on the synced selectors, not the bus copy
  // low-voltage filter
  supply_glitch_filter lvr_filter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .slow_tick(slow_tick),
    .time_select(aon_reg.lowvolt_glitch_time_select),
    .raw_in(lowvolt_cmp_raw),
    .filtered_out(lvr_below_f)
  );

  supply_glitch_filter bod_filter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .slow_tick(slow_tick),
    .time_select(aon_reg.brownout_glitch_time_select),
    .raw_in(brownout_cmp_raw),
    .filtered_out(bod_below_f)
  );

  // detector counts as live only when enabled with a real threshold
  // code 111 gives no detection
  assign bod_active = aon_reg.brownout_detector_enable &&
    (aon_reg.brownout_threshold_select != `THR_NONE);

  // filtered level change in either direction is a crossing
  // both directions
  assign crossing = bod_active && (bod_below_f != below_q_reg);

  assign events[`EV_CROSS] = crossing;
  assign events[`EV_BOD_RESET] = chip_rst_next & ~chip_rst_reg;
  assign events[`EV_LVR_TRIP] = lvr_rst_next & ~lvr_rst_reg;

  assign wr_ctrl = reg_req.wr && (reg_req.addr == `OFS_BOD_CTRL);
  assign wr_glitch = reg_req.wr && (reg_req.addr == `OFS_GLITCH_SEL);

  // register write side and the bus copy of the always-on fields
  always_comb
  begin
    cfg_next = cfg_reg;
    sync_en_next = sync_en_reg;
    irq_en_next = irq_en_reg;
    if (wr_ctrl)
    begin
      cfg_next.brownout_test_enable = reg_req.wdata[`POS_BOD_TEST];
      cfg_next.lowvolt_reset_test_enable = reg_req.wdata[`POS_LVR_TEST];
      cfg_next.brownout_threshold_select = reg_req.wdata[`POS_THR_HI:`POS_THR_LO];
      cfg_next.brownout_detector_enable = reg_req.wdata[`POS_BROWNOUT_DETECTOR_ENABLE_ALIAS];
      cfg_next.lowvolt_reset_enable = reg_req.wdata[`POS_LVR_EN];
      if (regs_unlocked)
      begin
        cfg_next.brownout_response_select = reg_req.wdata[`POS_RESP_SEL];
      end
    end
    if (wr_glitch)
    begin
      cfg_next.lowvolt_glitch_time_select = reg_req.wdata[`POS_LVR_DB_HI:`POS_LVR_DB_LO];
      cfg_next.brownout_glitch_time_select = reg_req.wdata[`POS_BOD_DB_HI:`POS_BOD_DB_LO];
    end
    if (reg_req.wr && (reg_req.addr == `OFS_AON_SYNC))
    begin
      sync_en_next = reg_req.wdata[0];
    end
    if (reg_req.wr && (reg_req.addr == `OFS_IRQ_ENABLE))
    begin
      irq_en_next = reg_req.wdata[2:0];
    end
  end

  // synced copy follows the bus copy only while sync is on
  // gated transfer to always-on side
  always_comb
  begin
    aon_next = aon_reg;
    if (sync_en_reg)
    begin
      aon_next = cfg_reg;
    end
  end

  // flag, response outputs and the event status
  always_comb
  begin
    flag_next = flag_reg;
    if (wr_ctrl && reg_req.wdata[`POS_BOD_FLAG])
    begin
      flag_next = 1'b0;
    end
    if (crossing)
    begin
      flag_next = 1'b1;
    end
    bod_irq_next = 1'b0;
    if (bod_active && !aon_reg.brownout_response_select)
    begin
      bod_irq_next = bod_irq_reg || (crossing && bod_below_f);
    end
    else if (aon_reg.brownout_detector_enable)
    begin
      bod_irq_next = bod_irq_reg; // select moved to reset: keep what was raised
    end
    chip_rst_next = bod_active && aon_reg.brownout_response_select && bod_below_f;
    lvr_rst_next = aon_reg.lowvolt_reset_enable && lvr_below_f;
    // sticky status, set wins over a same-cycle clear
    status_next = status_reg;
    if (reg_req.wr && (reg_req.addr == `OFS_IRQ_CLEAR))
    begin
      status_next = status_reg & ~reg_req.wdata[2:0];
    end
    status_next = status_next | events;
    irq_next = |(status_next & irq_en_next);
  end

  // readback views of the two documented registers
  // status is the inverted filtered comparator
  assign ctrl_view = {9'h000,
    cfg_reg.brownout_test_enable,
    cfg_reg.lowvolt_reset_test_enable,
    cfg_reg.brownout_threshold_select,
    cfg_reg.brownout_detector_enable,
    cfg_reg.lowvolt_reset_enable,
    9'h000,
    ~bod_below_f,
    1'b0,
    flag_reg,
    cfg_reg.brownout_response_select,
    3'h0};
  assign glitch_view = {18'h0_0000,
    cfg_reg.lowvolt_glitch_time_select,
    2'h0,
    cfg_reg.brownout_glitch_time_select};

  // read data valid only in the cycle after the strobe
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `OFS_BOD_CTRL: rdata_next = ctrl_view;
        `OFS_GLITCH_SEL: rdata_next = glitch_view;
        `OFS_AON_SYNC: rdata_next = {31'h0000_0000, sync_en_reg};
        `OFS_IRQ_STATUS: rdata_next = {29'h0000_0000, status_reg};
        `OFS_IRQ_ENABLE: rdata_next = {29'h0000_0000, irq_en_reg};
        default: rdata_next = 32'h0000_0000; // clear reg and holes read zero
      endcase
    end
  end

  // registers only
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_reg <= cfg_rst;
      aon_reg <= cfg_rst;
      sync_en_reg <= 1'b0;
      flag_reg <= 1'b0;
      bod_irq_reg <= 1'b0;
      chip_rst_reg <= 1'b0;
      lvr_rst_reg <= 1'b0;
      status_reg <= 3'h0;
      irq_en_reg <= 3'h0;
      irq_reg <= 1'b0;
      below_q_reg <= 1'b0;
      slow_q_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      cfg_reg <= cfg_next;
      aon_reg <= aon_next;
      sync_en_reg <= sync_en_next;
      flag_reg <= flag_next;
      bod_irq_reg <= bod_irq_next;
      chip_rst_reg <= chip_rst_next;
      lvr_rst_reg <= lvr_rst_next;
      status_reg <= status_next;
      irq_en_reg <= irq_en_next;
      irq_reg <= irq_next;
      below_q_reg <= bod_below_f;
      slow_q_reg <= slow_clk;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign brownout_irq = bod_irq_reg;
  assign chip_reset_req = chip_rst_reg;
  assign lowvolt_reset_req = lvr_rst_reg;
  assign irq = irq_reg;
  assign analog_ctrl = '{
    brownout_test_enable: aon_reg.brownout_test_enable,
    lowvolt_reset_test_enable: aon_reg.lowvolt_reset_test_enable,
    brownout_threshold_select: aon_reg.brownout_threshold_select,
    brownout_detector_enable: aon_reg.brownout_detector_enable,
    lowvolt_reset_enable: aon_reg.lowvolt_reset_enable
  };
endmodule // brownout_lvr_control

// >>> verification/brownout_lvr_chk.sv
// port assertions for the brown-out / low-voltage control block
// assumes one domain: ref_clk with async active-low reset_n
`timescale 1ns/1ps
module brownout_lvr_chk
  import brownout_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire brownout_pkg::reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic brownout_cmp_raw,
  input wire logic lowvolt_cmp_raw,
  input wire brownout_pkg::analog_ctrl_t analog_ctrl,
  input wire logic brownout_irq,
  input wire logic chip_reset_req,
  input wire logic lowvolt_reset_req
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // raw comparator seen below at the previous edge
  sequence s_bod_low;
    $past(brownout_cmp_raw);
  endsequence
  // no write taken at either of the last two edges
  sequence s_no_write2;
    !$past(reg_req.wr) && !$past(reg_req.wr, 2);
  endsequence

  AST_RDATA_IDLE: assert property (!reg_req.rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  AST_CTRL_STABLE: assert property (s_no_write2 |-> $stable(analog_ctrl))
    else $error("analog controls moved without a write");
  AST_BOD_OFF: assert property (!analog_ctrl.brownout_detector_enable
    && !$past(analog_ctrl.brownout_detector_enable) |-> !brownout_irq && !chip_reset_req)
    else $error("brown-out response while detector off");
  AST_LVR_OFF: assert property (!analog_ctrl.lowvolt_reset_enable
    && !$past(analog_ctrl.lowvolt_reset_enable) |-> !lowvolt_reset_req)
    else $error("low-voltage reset while disabled");
  AST_NO_THR: assert property (analog_ctrl.brownout_threshold_select == 3'h7
    && $past(analog_ctrl.brownout_threshold_select) == 3'h7 |-> !chip_reset_req)
    else $error("chip reset with no threshold");
  AST_RST_CAUSE: assert property ($rose(chip_reset_req) |-> s_bod_low)
    else $error("chip reset without comparator below");
  AST_IRQ_CAUSE: assert property ($rose(brownout_irq) |-> s_bod_low)
    else $error("brown-out interrupt without comparator below");
  AST_LVR_CAUSE: assert property ($rose(lowvolt_reset_req) |-> $past(lowvolt_cmp_raw))
    else $error("low-voltage reset without comparator below");
  AST_BIRQ_HOLD: assert property (brownout_irq
    && analog_ctrl.brownout_detector_enable |=> brownout_irq)
    else $error("brown-out interrupt dropped while enabled");
endmodule // brownout_lvr_chk

bind brownout_lvr_control brownout_lvr_chk brownout_lvr_chk_i (.ref_clk(ref_clk),
  .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .brownout_cmp_raw(brownout_cmp_raw), .lowvolt_cmp_raw(lowvolt_cmp_raw),
  .analog_ctrl(analog_ctrl), .brownout_irq(brownout_irq),
  .chip_reset_req(chip_reset_req), .lowvolt_reset_req(lowvolt_reset_req));

// >>> verification/supply_comparator_model.sv
// behavioural brown-out and low-voltage comparators
// assumes the bench gives the supply level in millivolts
`timescale 1ns/1ps
module supply_comparator_model
  import brownout_pkg::*;
(
  input wire logic [15:0] supply_mv,
  input wire brownout_pkg::analog_ctrl_t analog_ctrl,
  output logic brownout_cmp_raw,
  output logic lowvolt_cmp_raw
);
  // outputs high while below; a disabled comparator rests low
  always_comb
  begin
    // 200 mV steps from 1750, code 111 never trips
    brownout_cmp_raw = analog_ctrl.brownout_detector_enable
      && analog_ctrl.brownout_threshold_select != 3'h7
      && supply_mv < 1750 + 200 * analog_ctrl.brownout_threshold_select;
    lowvolt_cmp_raw = analog_ctrl.lowvolt_reset_enable && supply_mv < 16'd1700;
  end
endmodule // supply_comparator_model

// >>> verification/testbench.sv
// self-checking bench for the brown-out / low-voltage control block
// assumes the comparator model on the far side and a slow tick every 2 clocks
`timescale 1ns/1ps
`include "brownout_cfg.svh"
module testbench;
  import brownout_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic regs_unlocked = 1'b0;
  logic slow_clk = 1'b0;
  logic [15:0] supply_mv = 16'd3300;
  reg_req_t reg_req = '0;
  logic [31:0] reg_rdata, seed;
  logic brownout_cmp_raw, lowvolt_cmp_raw, brownout_irq, chip_reset_req;
  logic lowvolt_reset_req, irq, rd_seen;
  analog_ctrl_t analog_ctrl;
  logic [31:0] exp_q[$];
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  brownout_lvr_control brownout_lvr_control_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .regs_unlocked(regs_unlocked),
    .slow_clk(slow_clk), .brownout_cmp_raw(brownout_cmp_raw),
    .lowvolt_cmp_raw(lowvolt_cmp_raw), .analog_ctrl(analog_ctrl),
    .brownout_irq(brownout_irq), .chip_reset_req(chip_reset_req),
    .lowvolt_reset_req(lowvolt_reset_req), .irq(irq));
  supply_comparator_model supply_comparator_model_i (.supply_mv(supply_mv),
    .analog_ctrl(analog_ctrl), .brownout_cmp_raw(brownout_cmp_raw),
    .lowvolt_cmp_raw(lowvolt_cmp_raw));

  always #25 ref_clk = ~ref_clk;
  // slow tick on every other clock edge
  always @(posedge ref_clk) slow_clk <= ~slow_clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one-cycle strobes, a gap cycle so no signal is driven twice at one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge ref_clk);
    reg_req <= '0;
    @(posedge ref_clk);
  endtask

  // covers the longest filter chosen here plus register latency
  task automatic settle;
    repeat (40) @(posedge ref_clk);
  endtask

  // read data stand only in the cycle after the strobe: look mid-cycle
  always @(posedge ref_clk) rd_seen <= reg_req.rd;
  always @(negedge ref_clk)
    if (rd_seen)
      check("reg_rdata", reg_rdata, exp_q.pop_front());

  // hang guard, far above the few hundred cycles of the sequence
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      conclude();
    end
  end

  initial
  begin
    seed = 32'h8998_d06c;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check("analog_ctrl", analog_ctrl, 7'h0c);
    rd(`OFS_BOD_CTRL, `RST_BOD_CTRL);
    rd(`OFS_GLITCH_SEL, `RST_GLITCH_SEL);
    rd(8'h20, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr_next(seed);
      wr(`OFS_GLITCH_SEL, seed & 32'h0000_3f3f);
      rd(`OFS_GLITCH_SEL, seed & 32'h0000_3f3f);
    end
    wr(`OFS_GLITCH_SEL, 32'h0000_0124);
    wr(`OFS_BOD_CTRL, 32'h000b_0008);
    rd(`OFS_BOD_CTRL, 32'h000b_0040);
    settle;
    check("analog_ctrl", analog_ctrl, 7'h0c);
    wr(`OFS_AON_SYNC, 32'h0000_0001);
    settle;
    rd(`OFS_AON_SYNC, 32'h0000_0001);
    // dip of three ticks under a four-tick filter must vanish
    supply_mv <= 16'd2000;
    repeat (6) @(posedge ref_clk);
    supply_mv <= 16'd3300;
    settle;
    check("brownout_irq", brownout_irq, 1'b0);
    supply_mv <= 16'd2000;
    settle;
    check("brownout_irq", brownout_irq, 1'b1);
    rd(`OFS_BOD_CTRL, 32'h000b_0010);
    wr(`OFS_IRQ_ENABLE, 32'h0000_0001);
    settle;
    check("irq", irq, 1'b1);
    wr(`OFS_BOD_CTRL, 32'h000b_0000);
    rd(`OFS_BOD_CTRL, 32'h000b_0010);
    wr(`OFS_BOD_CTRL, 32'h000b_0010);
    wr(`OFS_IRQ_CLEAR, 32'h0000_0001);
    settle;
    rd(`OFS_BOD_CTRL, 32'h000b_0000);
    check("brownout_irq", brownout_irq, 1'b1);
    check("irq", irq, 1'b0);
    wr(`OFS_BOD_CTRL, 32'h0009_0000);
    settle;
    check("brownout_irq", brownout_irq, 1'b0);
    wr(`OFS_BOD_CTRL, 32'h000b_0000);
    settle;
    wr(`OFS_BOD_CTRL, 32'h000b_0010);
    supply_mv <= 16'd3300;
    settle;
    rd(`OFS_BOD_CTRL, 32'h000b_0050);
    regs_unlocked <= 1'b1;
    wr(`OFS_BOD_CTRL, 32'h000b_0018);
    rd(`OFS_BOD_CTRL, 32'h000b_0048);
    supply_mv <= 16'd1600;
    settle;
    check("chip_reset_req", chip_reset_req, 1'b1);
    check("lowvolt_reset_req", lowvolt_reset_req, 1'b1);
    rd(`OFS_IRQ_STATUS, 32'h0000_0007);
    wr(`OFS_BOD_CTRL, 32'h007f_0000);
    settle;
    check("analog_ctrl", analog_ctrl, 7'h7f);
    check("chip_reset_req", chip_reset_req, 1'b0);
    conclude();
  end
endmodule // testbench
